// ### hw/ccm_frame_security_header.v
// Frame security header engine: builds transmit headers, checks receive headers.
// Assumes a Wishbone classic master and an outside CCM core that reports tag checks.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_frame_security_consts.vh"
module ccm_frame_security_header (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire tx_req_i,
  input wire tx_link_control_data_unit_i,
  output wire tx_ready_o,
  output reg tx_refused_o,
  output wire tx_hdr_valid_o,
  output wire [7:0] tx_hdr_data_o,
  input wire tx_hdr_ready_i,
  output reg [31:0] tx_fn_o,
  output reg tx_encrypt_o,
  output reg [4:0] tx_tag_len_o,
  output reg [1:0] tx_key_type_o,
  output reg tx_key_id_o,
  output reg tx_unenc_en_o,
  input wire rx_first_seg_i,
  input wire [1:0] rx_seg_pri_i,
  input wire [3:0] rx_orig_i,
  input wire rx_hdr_valid_i,
  input wire [7:0] rx_hdr_data_i,
  output wire rx_hdr_ready_o,
  output reg [1:0] rx_key_type_o,
  output reg rx_key_id_o,
  output reg rx_decrypt_o,
  output reg [4:0] rx_tag_len_o,
  output reg [31:0] rx_fn_o,
  output reg rx_verify_start_o,
  input wire rx_mic_done_i,
  input wire rx_mic_ok_i,
  output reg rx_accept_o,
  output reg rx_drop_o,
  output reg [2:0] rx_drop_reason_o
);
  localparam [2:0] S_HDR = 3'h0;
  localparam [2:0] S_DECODE = 3'h1;
  localparam [2:0] S_LOOK = 3'h2;
  localparam [2:0] S_CHECK = 3'h3;
  localparam [2:0] S_MIC = 3'h4;

  // Merges write data into a register under the byte enables.
  function [31:0] merge_sel;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      merge_sel = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_sel[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // Tag length code for a protection level.
  function [2:0] level_code;
    input [1:0] lvl;
    begin
      case (lvl)
        `LVL_LOW: level_code = `TAG_CODE_4;
        `LVL_MED: level_code = `TAG_CODE_8;
        `LVL_HIGH: level_code = `TAG_CODE_16;
        default: level_code = `TAG_CODE_POP;
      endcase
    end
  endfunction

  // Tag length in bytes for a tag code; unknown codes give zero.
  function [4:0] code_bytes;
    input [2:0] code;
    begin
      case (code)
        `TAG_CODE_4: code_bytes = 5'h04;
        `TAG_CODE_8: code_bytes = 5'h08;
        `TAG_CODE_16: code_bytes = 5'h10;
        default: code_bytes = 5'h00;
      endcase
    end
  endfunction

  reg [31:0] ctrl_q;
  reg [31:0] fn_init_q;
  reg exhaust_q;
  reg [15:0] acc_cnt_q;
  reg [15:0] drop_cnt_q;
  reg [31:0] fn_key_q [0:1];
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i;
  wire [1:0] req_lvl = ctrl_q[`CTRL_LVL_LO +: 2];
  wire tx_kid = ctrl_q[`CTRL_KEY_ID];
  wire [1:0] tx_ktype = ctrl_q[`CTRL_KTYPE_LO +: 2];
  wire tx_pop = (req_lvl == `LVL_POP);
  wire new_key = wb_wr && (wb_adr_i == `REG_CMD) && wb_sel_i[0] && wb_dat_i[`CMD_TX_NEW_KEY];
  wire rx_key_chg = wb_wr && (wb_adr_i == `REG_CMD) && wb_sel_i[0] && wb_dat_i[`CMD_RX_KEY_CHG];
  wire [31:0] fn_cur = fn_key_q[tx_kid];
  wire [7:0] tx_ctrl_oct;
  wire bld_ready;
  wire tx_go;
  wire tx_block;
  reg [2:0] rx_state_q;
  reg rx_accept_now;
  reg rx_drop_now;

  // Order-only frames leave key fields at zero; bits 7..6 always zero.
  assign tx_ctrl_oct = tx_pop ? 8'h00 : {2'b00, tx_kid, tx_ktype, level_code(req_lvl)};
  // Encrypted frames never use the top value, so the key must change first.
  assign tx_block = !tx_pop && (fn_cur == `FN_MAX);
  assign tx_ready_o = bld_ready;
  assign tx_go = tx_req_i && bld_ready && !tx_block;

  sec_header_builder u_builder (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(tx_go),
    .ctrl_i(tx_ctrl_oct),
    .fn_i(fn_cur),
    .ready_o(bld_ready),
    .valid_o(tx_hdr_valid_o),
    .data_o(tx_hdr_data_o),
    .out_ready_i(tx_hdr_ready_i)
  );

  // Bus slave: registered ack one cycle after the strobe, unmapped reads zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `REG_CTRL) begin
          wb_dat_o <= {27'h0000000, ctrl_q[4:0]};
        end else if (wb_adr_i == `REG_FN_INIT) begin
          wb_dat_o <= fn_init_q;
        end else if (wb_adr_i == `REG_STATUS) begin
          wb_dat_o <= {27'h0000000, rx_drop_reason_o, (rx_state_q != S_HDR), exhaust_q};
        end else if (wb_adr_i == `REG_TX_FN) begin
          wb_dat_o <= fn_cur;
        end else if (wb_adr_i == `REG_RX_CNT) begin
          wb_dat_o <= {drop_cnt_q, acc_cnt_q};
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 32'h00000000;
      fn_init_q <= `FN_INIT_RST;
    end else begin
      if (wb_wr && wb_adr_i == `REG_CTRL) begin
        ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000001F;
      end
      if (wb_wr && wb_adr_i == `REG_FN_INIT) begin
        fn_init_q <= merge_sel(fn_init_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Exhaustion flag: a new refusal wins over a write-one clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      exhaust_q <= 1'b0;
    end else if (tx_req_i && bld_ready && tx_block) begin
      exhaust_q <= 1'b1;
    end else if (wb_wr && wb_adr_i == `REG_STATUS && wb_sel_i[0] && wb_dat_i[`ST_EXHAUST]) begin
      exhaust_q <= 1'b0;
    end
  end

  // One frame number counter per key slot.
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_fn
      always @(posedge clk_i) begin
        if (rst_i) begin
          fn_key_q[k] <= `FN_INIT_RST;
        end else if (new_key && tx_kid == k) begin
          fn_key_q[k] <= fn_init_q;
        end else if (tx_go && tx_kid == k) begin
          if (tx_pop && fn_key_q[k] == `FN_MAX) begin
            fn_key_q[k] <= `FN_WRAP;
          end else begin
            fn_key_q[k] <= fn_key_q[k] + 32'h00000001;
          end
        end
      end
    end
  endgenerate

  // Refusal flag registered every cycle; per-frame transmit attributes steady until the next accepted request.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_refused_o <= 1'b0;
      tx_fn_o <= 32'h00000000;
      tx_encrypt_o <= 1'b0;
      tx_tag_len_o <= 5'h00;
      tx_key_type_o <= 2'h0;
      tx_key_id_o <= 1'b0;
      tx_unenc_en_o <= 1'b0;
    end else begin
      tx_refused_o <= tx_req_i && bld_ready && tx_block;
      if (tx_go) begin
        tx_fn_o <= fn_cur;
        tx_encrypt_o <= !tx_pop;
        tx_tag_len_o <= code_bytes(level_code(req_lvl));
        tx_key_type_o <= tx_pop ? 2'h0 : tx_ktype;
        tx_key_id_o <= tx_pop ? 1'b0 : tx_kid;
        tx_unenc_en_o <= !tx_link_control_data_unit_i;
      end
    end
  end

  reg [2:0] rx_cnt_q;
  reg [39:0] rx_hdr_q;
  reg [1:0] rx_pri_q;
  reg [3:0] rx_orig_q;
  reg rx_pop_q;
  wire tbl_seen;
  wire [31:0] tbl_last;
  wire [7:0] rx_ctl = rx_hdr_q[39:32];
  wire [2:0] rx_code = rx_ctl[2:0];
  wire [31:0] rx_fn = rx_hdr_q[31:0];
  wire rx_code_ok = (rx_code == level_code(req_lvl));
  wire rx_order_ok = (rx_fn != 32'h00000000) && (!tbl_seen || rx_fn > tbl_last);
  assign rx_hdr_ready_o = (rx_state_q == S_HDR);

  replay_table u_table (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(rx_key_chg),
    .idx_i({rx_orig_q, rx_pri_q}),
    .seen_o(tbl_seen),
    .last_o(tbl_last),
    .wr_i(rx_accept_now),
    .wr_fn_i(rx_fn)
  );

  // Originator and priority come from the first segment of a frame.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_pri_q <= 2'h0;
      rx_orig_q <= 4'h0;
    end else if (rx_first_seg_i && rx_state_q == S_HDR) begin
      rx_pri_q <= rx_seg_pri_i;
      rx_orig_q <= rx_orig_i;
    end
  end

  always @* begin
    rx_accept_now = 1'b0;
    rx_drop_now = 1'b0;
    if (rx_state_q == S_CHECK) begin
      rx_drop_now = !rx_order_ok;
      rx_accept_now = rx_order_ok && rx_pop_q;
    end else if (rx_state_q == S_MIC && rx_mic_done_i) begin
      rx_accept_now = rx_mic_ok_i;
      rx_drop_now = !rx_mic_ok_i;
    end
  end

  // Receive check sequence: level and key first, then ordering, then the tag.
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_q <= S_HDR;
      rx_cnt_q <= 3'h0;
      rx_hdr_q <= 40'h0000000000;
      rx_pop_q <= 1'b0;
      rx_key_type_o <= 2'h0;
      rx_key_id_o <= 1'b0;
      rx_decrypt_o <= 1'b0;
      rx_tag_len_o <= 5'h00;
      rx_fn_o <= 32'h00000000;
      rx_verify_start_o <= 1'b0;
      rx_accept_o <= 1'b0;
      rx_drop_o <= 1'b0;
      rx_drop_reason_o <= `DROP_NONE;
      acc_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      rx_verify_start_o <= 1'b0;
      rx_accept_o <= rx_accept_now;
      rx_drop_o <= 1'b0;
      if (rx_accept_now) begin
        acc_cnt_q <= acc_cnt_q + 16'h0001;
        rx_drop_reason_o <= `DROP_NONE;
      end
      if (rx_drop_now) begin
        rx_drop_o <= 1'b1;
        drop_cnt_q <= drop_cnt_q + 16'h0001;
        rx_drop_reason_o <= (rx_state_q == S_MIC) ? `DROP_TAG : `DROP_ORDER;
      end
      case (rx_state_q)
        S_HDR: begin
          if (rx_hdr_valid_i) begin
            rx_hdr_q <= {rx_hdr_q[31:0], rx_hdr_data_i};
            if (rx_cnt_q == `HDR_BYTES - 3'h1) begin
              rx_cnt_q <= 3'h0;
              rx_state_q <= S_DECODE;
            end else begin
              rx_cnt_q <= rx_cnt_q + 3'h1;
            end
          end
        end
        S_DECODE: begin
          rx_pop_q <= (rx_code == `TAG_CODE_POP);
          rx_fn_o <= rx_fn;
          rx_decrypt_o <= (rx_code != `TAG_CODE_POP);
          rx_tag_len_o <= code_bytes(rx_code);
          // Bits 7..6 never take part; key fields are ignored in order-only frames.
          rx_key_type_o <= (rx_code == `TAG_CODE_POP) ? 2'h0 : rx_ctl[4:3];
          rx_key_id_o <= (rx_code == `TAG_CODE_POP) ? 1'b0 : rx_ctl[5];
          if (!rx_code_ok) begin
            rx_drop_o <= 1'b1;
            rx_drop_reason_o <= `DROP_LEVEL;
            drop_cnt_q <= drop_cnt_q + 16'h0001;
            rx_state_q <= S_HDR;
          end else if (rx_code != `TAG_CODE_POP && rx_ctl[4:3] == `KEY_TYPE_RSVD) begin
            rx_drop_o <= 1'b1;
            rx_drop_reason_o <= `DROP_KEY;
            drop_cnt_q <= drop_cnt_q + 16'h0001;
            rx_state_q <= S_HDR;
          end else begin
            rx_state_q <= S_LOOK;
          end
        end
        S_LOOK: begin
          rx_state_q <= S_CHECK;
        end
        S_CHECK: begin
          if (!rx_order_ok || rx_pop_q) begin
            rx_state_q <= S_HDR;
          end else begin
            // Header bytes are part of what the core authenticates.
            rx_verify_start_o <= 1'b1;
            rx_state_q <= S_MIC;
          end
        end
        S_MIC: begin
          if (rx_mic_done_i) begin
            rx_state_q <= S_HDR;
          end
        end
        default: begin
          rx_state_q <= S_HDR;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### hw/ccm_frame_security_consts.vh
// Constants for the frame security header block.
// Assumes inclusion by bare name from the design files.
`ifndef CCM_FRAME_SECURITY_CONSTS_VH
`define CCM_FRAME_SECURITY_CONSTS_VH
`define HDR_BYTES 3'h5
`define TAG_CODE_POP 3'h0
`define TAG_CODE_4 3'h1
`define TAG_CODE_8 3'h3
`define TAG_CODE_16 3'h7
`define LVL_POP 2'h0
`define LVL_LOW 2'h1
`define LVL_MED 2'h2
`define LVL_HIGH 2'h3
`define KEY_TYPE_RSVD 2'h3
`define FN_MAX 32'hFFFFFFFF
`define FN_INIT_RST 32'h00000001
`define FN_WRAP 32'h00000001
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_FN_INIT 8'h08
`define REG_STATUS 8'h0C
`define REG_TX_FN 8'h10
`define REG_RX_CNT 8'h14
`define CTRL_LVL_LO 0
`define CTRL_KEY_ID 2
`define CTRL_KTYPE_LO 3
`define CMD_TX_NEW_KEY 0
`define CMD_RX_KEY_CHG 1
`define ST_EXHAUST 0
`define ST_RX_BUSY 1
`define DROP_NONE 3'h0
`define DROP_LEVEL 3'h1
`define DROP_KEY 3'h2
`define DROP_ORDER 3'h3
`define DROP_TAG 3'h4
`endif

// ### hw/sec_header_builder.v
// Serialises the 5-byte security header, control octet first.
// Assumes the caller loads it only while ready_o is high.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_frame_security_consts.vh"
module sec_header_builder (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [7:0] ctrl_i,
  input wire [31:0] fn_i,
  output wire ready_o,
  output wire valid_o,
  output reg [7:0] data_o,
  input wire out_ready_i
);
  reg [2:0] left_q;
  reg [31:0] rest_q;
  assign ready_o = (left_q == 3'h0);
  assign valid_o = (left_q != 3'h0);
  always @(posedge clk_i) begin
    if (rst_i) begin
      left_q <= 3'h0;
      rest_q <= 32'h00000000;
      data_o <= 8'h00;
    end else if (load_i && ready_o) begin
      left_q <= `HDR_BYTES;
      data_o <= ctrl_i;
      rest_q <= fn_i;
    end else if (valid_o && out_ready_i) begin
      // Frame number goes out most significant octet first.
      left_q <= left_q - 3'h1;
      data_o <= rest_q[31:24];
      rest_q <= {rest_q[23:0], 8'h00};
    end
  end
endmodule
`default_nettype wire

// ### hw/replay_table.v
// Last accepted frame number per originator and priority.
// Assumes one lookup or update at a time; read data follows one cycle.
`timescale 1ns/1ps
`default_nettype none
module replay_table (
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire [5:0] idx_i,
  output reg seen_o,
  output reg [31:0] last_o,
  input wire wr_i,
  input wire [31:0] wr_fn_i
);
  reg [31:0] fn_mem [0:63];
  reg [63:0] seen_q;
  always @(posedge clk_i) begin
    if (wr_i) begin
      fn_mem[idx_i] <= wr_fn_i;
    end
    last_o <= fn_mem[idx_i];
  end
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      seen_q <= 64'h0000000000000000;
      seen_o <= 1'b0;
    end else begin
      if (wr_i) begin
        seen_q[idx_i] <= 1'b1;
      end
      seen_o <= seen_q[idx_i];
    end
  end
endmodule
`default_nettype wire

// ### testbench/ccm_sec_hdr_sva.sv
// Port assertions for the frame security header block.
// Assumes it is bound onto ccm_frame_security_header.
`timescale 1ns/1ps
`default_nettype none
module ccm_sec_hdr_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_link_control_data_unit_i,
  input wire logic tx_refused_o,
  input wire logic tx_hdr_valid_o,
  input wire logic [7:0] tx_hdr_data_o,
  input wire logic tx_hdr_ready_i,
  input wire logic [31:0] tx_fn_o,
  input wire logic tx_encrypt_o,
  input wire logic [4:0] tx_tag_len_o,
  input wire logic [1:0] tx_key_type_o,
  input wire logic tx_key_id_o,
  input wire logic tx_unenc_en_o,
  input wire logic rx_decrypt_o,
  input wire logic rx_verify_start_o,
  input wire logic rx_mic_done_i,
  input wire logic rx_mic_ok_i,
  input wire logic rx_accept_o,
  input wire logic rx_drop_o,
  input wire logic [2:0] rx_drop_reason_o
);
  wire [2:0] code = tx_tag_len_o == 5'h10 ? 3'h7 : tx_tag_len_o == 5'h08 ? 3'h3 : 3'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence hdr_start;
    $rose(tx_hdr_valid_o);
  endsequence
  sequence hdr_drain;
    hdr_start ##0 tx_hdr_ready_i [*5];
  endsequence
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  hdr_length_a: assert property (hdr_drain |=> !tx_hdr_valid_o)
    else $error("header length wrong");
  hdr_ctrl_a: assert property (hdr_start |-> tx_hdr_data_o[5:0] ==
    (tx_encrypt_o ? {tx_key_id_o, tx_key_type_o, code} : 6'h00)) else $error("control octet wrong");
  hdr_spare_a: assert property (hdr_start |-> tx_hdr_data_o[7:6] == 2'h0)
    else $error("spare bits set");
  level_enc_a: assert property (hdr_start |-> tx_encrypt_o == (tx_tag_len_o != 5'h00))
    else $error("tag length and encryption disagree");
  fn_order_a: assert property (hdr_start ##0 tx_hdr_ready_i |=> tx_hdr_data_o == tx_fn_o[31:24])
    else $error("frame number byte order wrong");
  clear_part_a: assert property (hdr_start |-> tx_unenc_en_o == !$past(tx_link_control_data_unit_i))
    else $error("clear part flag wrong");
  refuse_idle_a: assert property (tx_refused_o |-> !tx_hdr_valid_o)
    else $error("refused request still sent");
  verify_key_a: assert property (rx_verify_start_o |-> rx_decrypt_o)
    else $error("verify without decrypt");
  mic_bad_a: assert property (rx_mic_done_i && !rx_mic_ok_i |=> rx_drop_o && rx_drop_reason_o == 3'h4)
    else $error("bad tag not dropped");
  mic_good_a: assert property (rx_mic_done_i && rx_mic_ok_i |=> rx_accept_o && !rx_drop_o)
    else $error("good tag not accepted");
endmodule
bind ccm_frame_security_header ccm_sec_hdr_sva chk (.*);
`default_nettype wire

// ### testbench/peer_link_model.sv
// Far-side link layer: sinks transmit header bytes and sources receive headers.
// Assumes the bench calls send_hdr and reads the got queue.
`timescale 1ns/1ps
`default_nettype none
module peer_link_model (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic seg_o,
  output logic [1:0] pri_o,
  output logic [3:0] orig_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_ready_i,
  input wire logic verify_i,
  output logic mic_done_o,
  output logic mic_ok_o
);
  logic stall = 1'h0;
  logic mic_good = 1'h1;
  logic [3:0] mic_lat = 4'h1;
  logic [3:0] wait_q = 4'h0;
  logic [7:0] got[$];
  initial begin
    {tx_ready_o, seg_o, pri_o, orig_o, rx_valid_o, rx_data_o, mic_done_o, mic_ok_o} = '0;
  end
  // A stalled sink takes a byte only every second cycle.
  always @(posedge clk_i) begin
    tx_ready_o <= !stall || !tx_ready_o;
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    wait_q <= verify_i ? mic_lat : (wait_q != 4'h0 ? wait_q - 4'h1 : 4'h0);
    mic_done_o <= wait_q == 4'h1;
    mic_ok_o <= (wait_q == 4'h1) ? mic_good : !mic_good;
  end
  task automatic send_hdr(input logic [7:0] c, input logic [31:0] fn, input logic [3:0] o, input logic [1:0] p);
    logic [39:0] sh;
    sh = {c, fn};
    @(posedge clk_i);
    seg_o <= 1'h1;
    orig_o <= o;
    pri_o <= p;
    @(posedge clk_i);
    seg_o <= 1'h0;
    orig_o <= ~o;
    pri_o <= ~p;
    for (int i = 0; i < 5; i++) begin
      rx_valid_o <= 1'h1;
      rx_data_o <= sh[39:32];
      sh = sh << 8;
      do @(posedge clk_i); while (!rx_ready_i);
    end
    rx_valid_o <= 1'h0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the frame security header block.
// Assumes the peer model on the header streams and a Wishbone master here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, tx_req_i = 1'h0, tx_link_control_data_unit_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rdat;
  wire [31:0] wb_dat_o, tx_fn_o, rx_fn_o;
  wire [7:0] tx_hdr_data_o, rx_hdr_data_i;
  wire [4:0] tx_tag_len_o, rx_tag_len_o;
  wire [3:0] rx_orig_i;
  wire [2:0] rx_drop_reason_o;
  wire [1:0] tx_key_type_o, rx_key_type_o, rx_seg_pri_i;
  wire wb_ack_o, tx_ready_o, tx_refused_o, tx_hdr_valid_o, tx_hdr_ready_i, tx_encrypt_o, tx_key_id_o;
  wire tx_unenc_en_o, rx_first_seg_i, rx_hdr_valid_i, rx_hdr_ready_o, rx_key_id_o, rx_decrypt_o;
  wire rx_verify_start_o, rx_mic_done_i, rx_mic_ok_i, rx_accept_o, rx_drop_o;
  int error_cnt = 0;
  int n_checks = 0;
  ccm_frame_security_header uut (.*);
  peer_link_model peer (.clk_i(clk_i), .tx_valid_i(tx_hdr_valid_o), .tx_data_i(tx_hdr_data_o),
    .tx_ready_o(tx_hdr_ready_i), .seg_o(rx_first_seg_i), .pri_o(rx_seg_pri_i), .orig_o(rx_orig_i),
    .rx_valid_o(rx_hdr_valid_i), .rx_data_o(rx_hdr_data_i), .rx_ready_i(rx_hdr_ready_o),
    .verify_i(rx_verify_start_o), .mic_done_o(rx_mic_done_i), .mic_ok_o(rx_mic_ok_i));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    chk("bus ack", 1, wb_ack_o);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 4'hF, 32'h0);
    chk("register read", e, rdat);
  endtask
  task automatic tx(input logic link_control_data_unit, input logic [7:0] c, input logic [31:0] fn);
    int n;
    n = 0;
    peer.got.delete();
    @(posedge clk_i);
    {tx_req_i, tx_link_control_data_unit_i} <= {1'h1, link_control_data_unit};
    @(posedge clk_i);
    tx_req_i <= 1'h0;
    @(posedge clk_i);
    chk("tx ready while busy", 0, tx_ready_o);
    while (peer.got.size() < 5 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk("header bytes", 5, peer.got.size());
    if (peer.got.size() == 5) chk("header control", c, peer.got[0]);
    if (peer.got.size() == 5) chk("header fn", fn, {peer.got[1], peer.got[2], peer.got[3], peer.got[4]});
    chk("tx frame number", fn, tx_fn_o);
    chk("tx clear part", !link_control_data_unit, tx_unenc_en_o);
  endtask
  task automatic rx(input logic [7:0] c, input logic [31:0] fn, input logic [5:0] op, input logic ok, input logic [2:0] why);
    int n;
    n = 0;
    peer.mic_good = ok;
    peer.send_hdr(c, fn, op[5:2], op[1:0]);
    while (rx_accept_o !== 1'h1 && rx_drop_o !== 1'h1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk("rx accept", why == 3'h0, rx_accept_o);
    if (why != 3'h0) chk("rx drop reason", why, rx_drop_reason_o);
    chk("rx frame number", fn, rx_fn_o);
    if (c[2:0] == 3'h3) chk("rx tag length", 8, rx_tag_len_o);
    if (c[2:0] != 3'h0) chk("rx key", {c[4:3], c[5]}, {rx_key_type_o, rx_key_id_o});
  endtask
  task automatic regs_test;
    rc(8'h00, 32'h0);
    rc(8'h08, 32'h1);
    rc(8'h10, 32'h1);
    rc(8'h3C, 32'h0);
    wb(1'h1, 8'h08, 4'h0, 32'h55);
    rc(8'h08, 32'h1);
  endtask
  task automatic tx_levels_test;
    logic [1:0] kt;
    for (int l = 0; l < 4; l++) begin
      kt = l % 3;
      wb(1'h1, 8'h00, 4'hF, {kt, l[0], l[1:0]});
      wb(1'h1, 8'h04, 4'hF, 32'h1);
      tx(l[0], l == 0 ? 8'h00 : {2'h0, l[0], kt, l == 3 ? 3'h7 : l == 2 ? 3'h3 : 3'h1}, 32'h1);
      tx(!l[0], l == 0 ? 8'h00 : {2'h0, l[0], kt, l == 3 ? 3'h7 : l == 2 ? 3'h3 : 3'h1}, 32'h2);
    end
  endtask
  task automatic tx_wrap_test;
    peer.stall = 1'h1;
    wb(1'h1, 8'h08, 4'hF, 32'hFFFFFFFE);
    wb(1'h1, 8'h00, 4'hF, 32'h3);
    wb(1'h1, 8'h04, 4'hF, 32'h1);
    tx(1'h0, 8'h07, 32'hFFFFFFFE);
    @(posedge clk_i);
    tx_req_i <= 1'h1;
    @(posedge clk_i);
    tx_req_i <= 1'h0;
    @(posedge clk_i);
    chk("tx refused", 1, tx_refused_o);
    rc(8'h0C, 32'h1);
    wb(1'h1, 8'h0C, 4'hF, 32'h1);
    wb(1'h1, 8'h08, 4'hF, 32'hFFFFFFFF);
    wb(1'h1, 8'h00, 4'hF, 32'h0);
    wb(1'h1, 8'h04, 4'hF, 32'h1);
    tx(1'h1, 8'h00, 32'hFFFFFFFF);
    tx(1'h0, 8'h00, 32'h1);
    peer.stall = 1'h0;
  endtask
  task automatic rx_test;
    wb(1'h1, 8'h00, 4'hF, 32'h2);
    rx(8'h03, 32'h5, 6'h0D, 1'h1, 3'h0);
    rx(8'h03, 32'h5, 6'h0D, 1'h1, 3'h3);
    peer.mic_lat = 4'h6;
    rx(8'h03, 32'h6, 6'h0D, 1'h0, 3'h4);
    rx(8'hC3, 32'h6, 6'h0D, 1'h1, 3'h0);
    rx(8'h03, 32'h0, 6'h1C, 1'h1, 3'h3);
    rx(8'h01, 32'h9, 6'h1C, 1'h1, 3'h1);
    rx(8'h07, 32'h9, 6'h1C, 1'h1, 3'h1);
    rx(8'h1B, 32'h9, 6'h1C, 1'h1, 3'h2);
    rx(8'h2B, 32'h5, 6'h0E, 1'h1, 3'h0);
    wb(1'h1, 8'h04, 4'hF, 32'h2);
    rx(8'h03, 32'h5, 6'h0D, 1'h1, 3'h0);
    wb(1'h1, 8'h00, 4'hF, 32'h0);
    rx(8'hF8, 32'h3, 6'h07, 1'h0, 3'h0);
    rx(8'h00, 32'h3, 6'h07, 1'h1, 3'h3);
    rc(8'h0C, 32'h0000000C);
    rc(8'h14, 32'h00070005);
  endtask
  initial begin
    #400000;
    error_cnt++;
    $display("unexpected timeout: expected end seen hang");
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    regs_test();
    tx_levels_test();
    tx_wrap_test();
    rx_test();
    stop_test();
  end
endmodule
`default_nettype wire
